// [hw/mss_fetch_arb.sv]
// Fetch arbiter: splits the slot when the added access stage meets a fetch.
// Assumes access and fetch_req are driven on clk by the controller.
`timescale 1ns/1ps
module mss_fetch_arb (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Slot carrier
    mss_slot_if.arb   slot
);

    logic pend_q;
    logic grant_q;
    logic defer_q;

    // ********************************************************
    // Deferred fetch
    // ********************************************************
    // The fetch waits its turn instead of merging into the access slot
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= (slot.fetch_req | pend_q) & slot.access;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            grant_q <= 1'b0;
            defer_q <= 1'b0;
        end else begin
            grant_q <= (slot.fetch_req | pend_q) & ~slot.access;
            defer_q <= (slot.fetch_req | pend_q) & slot.access;
        end
    end

    assign slot.fetch_grant = grant_q;
    assign slot.fetch_defer = defer_q;

    // ********************************************************
    // Checks
    // ********************************************************
    AST_FETCH_SPLIT: assert property (@(posedge clk) disable iff (!resetn)
        slot.access && slot.fetch_req |=> defer_q && !grant_q)
        else $error("fetch merged into access slot");

    AST_DEFER_RESUME: assert property (@(posedge clk) disable iff (!resetn)
        pend_q && !slot.access |=> grant_q && !defer_q)
        else $error("deferred fetch not resumed");

endmodule

// [hw/mss_pkg.sv]
// Shared types for the accumulator store stall control.
// Assumes one core clock; all inputs come from pipeline logic on that clock.
package mss_pkg;

    // ********************************************************
    // Slot states
    // ********************************************************
    typedef enum logic [1:0] {
        MSS_IDLE    = 2'b00,
        MSS_STRETCH = 2'b01,
        MSS_ACCESS  = 2'b10
    } mss_state_t;

    // ********************************************************
    // Store forms
    // ********************************************************
    typedef enum logic {
        MSS_KIND_REG = 1'b0,
        MSS_KIND_MEM = 1'b1
    } mss_kind_t;

    // Memory-access stage length in cycles once the multiplier is free
    localparam int unsigned MSS_ACCESS_CYCLES = 1;

endpackage

// [hw/mss_slot_if.sv]
// Carrier between the stall controller and its fetch arbiter.
// Assumes both ends share clk and resetn.
`timescale 1ns/1ps
interface mss_slot_if;
    logic access;
    logic fetch_req;
    logic fetch_grant;
    logic fetch_defer;

    modport ctrl (output access, output fetch_req, input fetch_grant, input fetch_defer);
    modport arb  (input access, input fetch_req, output fetch_grant, output fetch_defer);
endinterface

// [hw/mss_stall_ctrl.sv]
// Stall control for an accumulator store issued right behind a long multiply-accumulate.
// Assumes all inputs come from pipeline logic on clk; mult_busy is high while the multiplier works.
`timescale 1ns/1ps
module mss_stall_ctrl #(
    parameter bit CACHED_VARIANT = 1'b0
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // Store entering its access stage
    input  wire logic          ex_store_valid,
    input  mss_pkg::mss_kind_t ex_store_kind,
    // Multiplier and cache state
    input  wire logic          mult_busy,
    input  wire logic          cache_enable,
    // Instruction fetch
    input  wire logic          fetch_req,
    output logic               fetch_grant,
    output logic               fetch_defer,
    // Access stage status
    output logic               ma_active,
    output logic               mult_read,
    output logic               mem_write,
    output logic               store_done,
    output logic               pipeline_hold
);

    // ********************************************************
    // State
    // ********************************************************
    mss_pkg::mss_state_t state_q;
    mss_pkg::mss_state_t state_d;
    mss_pkg::mss_kind_t  kind_q;
    mss_pkg::mss_kind_t  kind_d;
    logic                accept;
    logic                wait_needed;
    logic                ma_active_q;
    logic                mult_read_q;
    logic                mem_write_q;
    logic                store_done_q;
    logic                hold_q;

    mss_slot_if slot ();

    // New store only taken when the slot is free; the hold keeps issue back
    // A store offered mid-slot is dropped, so issue must keep it while pipeline_hold is high
    assign accept = ex_store_valid && (state_q == mss_pkg::MSS_IDLE);
    assign kind_d = accept ? ex_store_kind : kind_q;

    // Cache hides the multiplier only for the memory form on the cached core
    always_comb begin
        wait_needed = 1'b1;
        if (kind_d == mss_pkg::MSS_KIND_MEM) begin
            wait_needed = !(CACHED_VARIANT && cache_enable);
        end
    end

    // ********************************************************
    // Slot sequencing
    // ********************************************************
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            mss_pkg::MSS_IDLE: begin
                if (accept) begin
                    if (wait_needed && mult_busy) begin
                        state_d = mss_pkg::MSS_STRETCH;
                    end else begin
                        state_d = mss_pkg::MSS_ACCESS;
                    end
                end
            end
            mss_pkg::MSS_STRETCH: begin
                if (!mult_busy) begin
                    state_d = mss_pkg::MSS_ACCESS;
                end
            end
            mss_pkg::MSS_ACCESS: begin
                state_d = mss_pkg::MSS_IDLE;
            end
            default: begin
                state_d = mss_pkg::MSS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= mss_pkg::MSS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            kind_q <= mss_pkg::MSS_KIND_REG;
        end else begin
            kind_q <= kind_d;
        end
    end

    // ********************************************************
    // Registered status
    // ********************************************************
    // Decoded from next state so each output lines up with its own cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ma_active_q <= 1'b0;
            mult_read_q <= 1'b0;
            mem_write_q <= 1'b0;
        end else begin
            ma_active_q <= (state_d != mss_pkg::MSS_IDLE);
            mult_read_q <= (state_d == mss_pkg::MSS_ACCESS);
            mem_write_q <= (state_d == mss_pkg::MSS_ACCESS) &&
                           (kind_d == mss_pkg::MSS_KIND_MEM);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            store_done_q <= 1'b0;
        end else begin
            store_done_q <= (state_q == mss_pkg::MSS_ACCESS);
        end
    end

    // Following instructions stay held for the whole merged slot
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_q <= 1'b0;
        end else begin
            hold_q <= (state_d != mss_pkg::MSS_IDLE);
        end
    end

    // ********************************************************
    // Fetch contention
    // ********************************************************
    // Only the access cycle uses the bus; a stretch leaves fetch free
    assign slot.access    = (state_d == mss_pkg::MSS_ACCESS);
    assign slot.fetch_req = fetch_req;

    mss_fetch_arb u_arb (
        .clk    (clk),
        .resetn (resetn),
        .slot   (slot.arb)
    );

    // ********************************************************
    // Outputs
    // ********************************************************
    assign fetch_grant   = slot.fetch_grant;
    assign fetch_defer   = slot.fetch_defer;
    assign ma_active     = ma_active_q;
    assign mult_read     = mult_read_q;
    assign mem_write     = mem_write_q;
    assign store_done    = store_done_q;
    assign pipeline_hold = hold_q;

    // ********************************************************
    // Checks
    // ********************************************************
    AST_REG_STRETCH: assert property (@(posedge clk) disable iff (!resetn)
        state_q == mss_pkg::MSS_IDLE && ex_store_valid &&
        ex_store_kind == mss_pkg::MSS_KIND_REG && mult_busy
        |=> state_q == mss_pkg::MSS_STRETCH && ma_active_q && !mult_read_q)
        else $error("register store did not stretch on busy multiplier");

    AST_STRETCH_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        state_q == mss_pkg::MSS_STRETCH && mult_busy
        |=> state_q == mss_pkg::MSS_STRETCH && hold_q)
        else $error("stretch ended while multiplier busy");

    AST_STRETCH_END: assert property (@(posedge clk) disable iff (!resetn)
        state_q == mss_pkg::MSS_STRETCH && !mult_busy
        |=> state_q == mss_pkg::MSS_ACCESS && mult_read_q ##1 store_done_q)
        else $error("multiplier read missing after stretch");

    AST_MEM_CACHED: assert property (@(posedge clk) disable iff (!resetn)
        state_q == mss_pkg::MSS_IDLE && ex_store_valid &&
        ex_store_kind == mss_pkg::MSS_KIND_MEM && CACHED_VARIANT && cache_enable
        |=> state_q == mss_pkg::MSS_ACCESS && mem_write_q)
        else $error("cached memory store waited on multiplier");

    AST_MEM_WAIT: assert property (@(posedge clk) disable iff (!resetn)
        state_q == mss_pkg::MSS_IDLE && ex_store_valid &&
        ex_store_kind == mss_pkg::MSS_KIND_MEM && !(CACHED_VARIANT && cache_enable) && mult_busy
        |=> state_q == mss_pkg::MSS_STRETCH && !mem_write_q)
        else $error("memory store did not wait on multiplier");

    AST_ACCESS_ONE: assert property (@(posedge clk) disable iff (!resetn)
        state_q == mss_pkg::MSS_ACCESS
        |=> state_q == mss_pkg::MSS_IDLE && !mult_read_q && !mem_write_q && store_done_q)
        else $error("access stage longer than one cycle");

    AST_WRITE_IN_SLOT: assert property (@(posedge clk) disable iff (!resetn)
        mem_write_q |-> mult_read_q && kind_q == mss_pkg::MSS_KIND_MEM)
        else $error("memory write outside memory store access");

    AST_FETCH_BLOCK: assert property (@(posedge clk) disable iff (!resetn)
        $rose(mult_read_q) && $past(fetch_req) |-> !fetch_grant && fetch_defer)
        else $error("fetch granted in access slot");

    // Slot shape checked every cycle, not only at the transitions
    AST_SLOT_MERGED: assert property (@(posedge clk) disable iff (!resetn)
        state_q != mss_pkg::MSS_IDLE
        |-> ma_active_q && hold_q && (mult_read_q == (state_q == mss_pkg::MSS_ACCESS)))
        else $error("stretched span not held as one slot");

    // A stuck done would let issue logic retire the store twice
    AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!resetn)
        store_done_q |-> state_q == mss_pkg::MSS_IDLE && !ma_active_q ##1 !store_done_q)
        else $error("store done not a single pulse");

endmodule

// [verif/mac_store_stall_control_bench.sv]
// Self-checking bench for the accumulator store stall control.
// Assumes hw/ files compiled first; drives both core variants side by side.
`timescale 1ns/1ps
module mac_store_stall_control_bench;

    // ********************************************************
    // Stimulus and observation
    // ********************************************************
    logic               clk;
    logic               resetn;
    logic               ex_store_valid;
    mss_pkg::mss_kind_t ex_store_kind;
    logic               mult_busy;
    logic               cache_enable;
    logic               fetch_req;
    wire  [6:0]         obs_unc;
    wire  [6:0]         obs_cch;
    int                 err_total;
    int                 n_tests;

`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

    // ********************************************************
    // Both variants see the same stimulus
    // ********************************************************
    mss_stall_ctrl #(.CACHED_VARIANT(1'b0)) DUT (
        .clk(clk), .resetn(resetn), .ex_store_valid(ex_store_valid), .ex_store_kind(ex_store_kind),
        .mult_busy(mult_busy), .cache_enable(cache_enable), .fetch_req(fetch_req),
        .fetch_grant(obs_unc[0]), .fetch_defer(obs_unc[1]), .ma_active(obs_unc[2]), .mult_read(obs_unc[3]),
        .mem_write(obs_unc[4]), .store_done(obs_unc[5]), .pipeline_hold(obs_unc[6])
    );
    mss_stall_ctrl #(.CACHED_VARIANT(1'b1)) dut_cached (
        .clk(clk), .resetn(resetn), .ex_store_valid(ex_store_valid), .ex_store_kind(ex_store_kind),
        .mult_busy(mult_busy), .cache_enable(cache_enable), .fetch_req(fetch_req),
        .fetch_grant(obs_cch[0]), .fetch_defer(obs_cch[1]), .ma_active(obs_cch[2]), .mult_read(obs_cch[3]),
        .mem_write(obs_cch[4]), .store_done(obs_cch[5]), .pipeline_hold(obs_cch[6])
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ********************************************************
    // Expected outputs, cycle k after the take, access in cycle a
    // ********************************************************
    // Order: hold, done, write, read, active, defer, grant
    function automatic logic [6:0] exp_vec(input int a, input int k, input int f, input bit mem);
        logic ma;
        ma = (k >= 1) && (k <= a);
        return {ma, k == a + 1, mem && k == a, k == a, ma, f == a - 1 && k == a,
                (f == a - 1) ? k == a + 1 : k == f + 1};
    endfunction

    // Busy for nbusy edges, fetch in cycle f (negative: none), again: retry valid mid-slot
    task automatic run_store(input mss_pkg::mss_kind_t kind, input bit cache, input int nbusy, input int f,
                             input bit again);
        int  a_c;
        bit  mem;
        mem = kind == mss_pkg::MSS_KIND_MEM;
        a_c = (mem && cache) ? 1 : nbusy + 1;
        @(negedge clk);
        ex_store_valid = 1'b1;
        ex_store_kind  = kind;
        cache_enable   = cache;
        mult_busy      = nbusy > 0;
        fetch_req      = f == 0;
        for (int k = 1; k <= nbusy + 3 + int'(again); k++) begin
            @(negedge clk);
            `CHK("uncached outputs", exp_vec(nbusy + 1, k, f, mem), obs_unc)
            `CHK("cached outputs", exp_vec(a_c, k, f, mem), obs_cch)
            ex_store_valid = again && k == 1;
            mult_busy      = k < nbusy;
            fetch_req      = k == f;
        end
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_reg_nowait();
        run_store(mss_pkg::MSS_KIND_REG, 1'b0, 0, -1, 1'b0);
        $display("Test reg_nowait done");
    endtask
    task automatic t_reg_stretch();
        run_store(mss_pkg::MSS_KIND_REG, 1'b0, 3, -1, 1'b0);
        $display("Test reg_stretch done");
    endtask
    task automatic t_mem_cache_on();
        run_store(mss_pkg::MSS_KIND_MEM, 1'b1, 3, -1, 1'b0);
        $display("Test mem_cache_on done");
    endtask
    task automatic t_mem_cache_off();
        run_store(mss_pkg::MSS_KIND_MEM, 1'b0, 2, -1, 1'b0);
        $display("Test mem_cache_off done");
    endtask
    task automatic t_reg_fetch();
        run_store(mss_pkg::MSS_KIND_REG, 1'b1, 2, 2, 1'b0);
        $display("Test reg_fetch done");
    endtask
    task automatic t_mem_fetch();
        run_store(mss_pkg::MSS_KIND_MEM, 1'b1, 0, 0, 1'b0);
        $display("Test mem_fetch done");
    endtask
    task automatic t_mem_fetch_split();
        run_store(mss_pkg::MSS_KIND_MEM, 1'b1, 2, 2, 1'b0);
        $display("Test mem_fetch_split done");
    endtask
    task automatic t_fetch_in_stretch();
        run_store(mss_pkg::MSS_KIND_REG, 1'b0, 3, 1, 1'b0);
        $display("Test fetch_in_stretch done");
    endtask
    task automatic t_refused();
        run_store(mss_pkg::MSS_KIND_MEM, 1'b1, 2, -1, 1'b1);
        $display("Test refused done");
    endtask

    // ********************************************************
    // Verdict
    // ********************************************************
    task automatic complete_run();
        $display("Checks: %0d, mismatches: %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Whole run is under 100 cycles; allow plenty
    initial begin
        #(400 * 20);
        err_total++;
        complete_run();
    end

    initial begin
        err_total      = 0;
        n_tests        = 0;
        resetn         = 1'b0;
        ex_store_valid = 1'b0;
        ex_store_kind  = mss_pkg::MSS_KIND_REG;
        mult_busy      = 1'b0;
        cache_enable   = 1'b0;
        fetch_req      = 1'b0;
        repeat (4) @(negedge clk);
        `CHK("reset outputs", 14'h0, {obs_unc, obs_cch})
        resetn = 1'b1;
        t_reg_nowait();
        t_reg_stretch();
        t_mem_cache_on();
        t_mem_cache_off();
        t_reg_fetch();
        t_mem_fetch();
        t_mem_fetch_split();
        t_fetch_in_stretch();
        t_refused();
        complete_run();
    end

endmodule
